// >>> bench/scsd_periph.sv
// Purpose: Serial peripheral answering the port in master mode
// Assumes: Clock and data driven by the port
// Notes: Deselected, the data line shows the inverse of its last bit
`timescale 1ns/1ns
module scsd_periph (
  // Serial side
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  output logic miso,
  // Mode and data
  input wire logic clock_idle_level,
  input wire logic clock_capture_phase,
  input wire logic [7:0] tx,
  output logic [7:0] rx
);
  logic [2:0] idx;
  logic cap;
  logic held;
  always @(negedge ss_n) begin
    idx = 3'h0;
    cap = 1'b0;
  end
  // Capture on one edge, shift out on the other
  always @(sck) begin
    if (!ss_n && sck == (~clock_idle_level ^ clock_capture_phase)) begin
      rx = {rx[6:0], mosi};
      cap = 1'b1;
    end else if (!ss_n && (cap || !clock_capture_phase)) begin
      idx = idx + 3'h1;
    end
  end
  always @* begin
    if (!ss_n) begin
      held = tx[3'h7 - idx];
    end
  end
  assign miso = ss_n ? ~held : held;
endmodule

// >>> bench/scsd_properties.sv
// Purpose: Port checks for the serial port block
// Assumes: Zero-wait APB slave, one clock
// Notes: Bound into scsd_top
`timescale 1ns/1ns
module scsd_properties (
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire scsd_pkg::scsd_pin_in_t pin_in,
  input wire scsd_pkg::scsd_pins_t pin_out,
  input wire logic alt_func_en,
  input wire logic ss_pin_alt_en
);
  import scsd_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_setup:
    assert property (psel && !penable |=> pready) else $error("pready late");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("pready held");
  chk_err_ready:
    assert property (pslverr |-> pready) else $error("pslverr alone");
  chk_rdata_upper:
    assert property (pready |-> prdata[31:8] == 24'h0) else $error("prdata upper bits");
  chk_pins_gpio:
    assert property (!alt_func_en [*2] |-> !(pin_out.sck_oe || pin_out.mosi_oe
      || pin_out.miso_oe)) else $error("pins driven while off");
  chk_ss_alt:
    assert property (ss_pin_alt_en |-> alt_func_en) else $error("select pin without port");
  chk_master_roles:
    assert property (pin_out.sck_oe |-> !pin_out.miso_oe) else $error("master drives miso");
  chk_sck_half:
    assert property (pin_out.sck_oe && $changed(pin_out.sck_o) |=> $stable(pin_out.sck_o))
      else $error("sck half period short");
  chk_fault_drop:
    assert property (pin_out.sck_oe && ss_pin_alt_en && !pin_in.ss_n_i |-> ##[1:3]
      !alt_func_en) else $error("fault left port on");
endmodule
bind scsd_top scsd_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_in(pin_in), .pin_out(pin_out), .alt_func_en(alt_func_en),
  .ss_pin_alt_en(ss_pin_alt_en));

// >>> bench/tb_top.sv
// Purpose: Self-checking bench for the serial port block
// Assumes: Zero-wait APB slave, partner model on the serial side
// Notes: Master traffic in all four modes, then one slave byte
`timescale 1ns/1ns
module tb_top;
  import scsd_pkg::*;
  localparam logic [11:0] A_DATA = {2'h0, SCSD_ADDR_DATA};
  localparam logic [11:0] A_CTRL = {2'h0, SCSD_ADDR_CTRL};
  localparam logic [11:0] A_STAT = {2'h0, SCSD_ADDR_STAT};
  localparam logic [7:0] SL_BYTE = 8'h5B;
  logic pclk, presetn, psel, penable, pwrite, perr, ss_n, sel_n, clock_idle_level, clock_capture_phase, p_miso;
  logic slv, s_sck, s_mosi;
  logic pready, pslverr, alt_func_en, ss_pin_alt_en, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] ptx, prx;
  logic [2:0] code [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
  int dv [6] = '{4, 8, 16, 32, 64, 128};
  int fail_count, comparisons;
  scsd_pin_in_t pin_in;
  scsd_pins_t pin_out;
  wire logic sck_w = pin_out.sck_oe ? pin_out.sck_o : (slv ? s_sck : clock_idle_level);
  wire logic mosi_w = pin_out.mosi_oe ? pin_out.mosi_o : (slv ? s_mosi : ~pin_out.mosi_o);
  wire logic miso_w = pin_out.miso_oe ? pin_out.miso_o : p_miso;
  assign pin_in = {sck_w, mosi_w, miso_w, ss_n};
  always #25 pclk = ~pclk;
  scsd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .alt_func_en(alt_func_en),
    .ss_pin_alt_en(ss_pin_alt_en), .irq(irq));
  scsd_periph u_periph (.sck(sck_w), .mosi(mosi_w), .ss_n(sel_n), .miso(p_miso),
    .clock_idle_level(clock_idle_level), .clock_capture_phase(clock_capture_phase), .tx(ptx), .rx(prx));
  // ****************
  // Shared tasks
  // ****************
  task automatic finish_test();
    $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step();
    @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      finish_test();
    end
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    logic [31:0] r;
    apb(A_CTRL, 0, 0, r);
    chk("ctrl", r, {24'h0, SCSD_CTRL_RESET});
    apb(A_STAT, 0, 0, r);
    chk("stat", r, {24'h0, SCSD_STAT_RESET});
    apb(12'h0F0, 0, 0, r);
    chk("unmapped", {r[30:0], perr}, 32'h1);
    chk("alt", alt_func_en, 0);
  endtask
  task automatic t_fault();
    logic [31:0] r;
    apb(A_CTRL, 1, 32'h40, r);
    step();
    chk("alt", alt_func_en, 1);
    chk("ssalt", ss_pin_alt_en, 1);
    apb(A_STAT, 1, 32'h3, r);
    step();
    chk("ssalt", ss_pin_alt_en, 0);
    apb(A_STAT, 1, 0, r);
    apb(A_CTRL, 1, 32'hD0, r);
    ss_n <= 1'b0;
    repeat (3) @(posedge pclk);
    ss_n <= 1'b1;
    step();
    chk("irq", irq, 1);
    chk("alt", alt_func_en, 0);
    apb(A_CTRL, 1, 32'hD0, r);
    apb(A_CTRL, 0, 0, r);
    chk("ctrl", r, 32'h80);
    apb(A_STAT, 0, 0, r);
    chk("stat", r, 32'h10);
    apb(A_CTRL, 1, 0, r);
    apb(A_STAT, 0, 0, r);
    chk("stat", r, 0);
  endtask
  task automatic t_xfer(input int i);
    logic [31:0] r;
    logic v;
    int n, k, t0, t1;
    clock_idle_level <= i[0];
    clock_capture_phase <= i[1];
    ptx <= 8'h3C + i[7:0];
    apb(A_CTRL, 1, 0, r);
    apb(A_CTRL, 1, {24'h0, i == 0, 1'b1, code[i][2], 1'b1, i[0], i[1], code[i][1:0]}, r);
    if (i == 4) begin
      apb(A_STAT, 1, 32'h4, r);
      step();
      chk("mosi_oe", pin_out.mosi_oe, 0);
      chk("sck_oe", pin_out.sck_oe, 1);
      apb(A_STAT, 1, 0, r);
    end
    sel_n <= 1'b0;
    step();
    chk("idle", pin_out.sck_o, i[0]);
    chk("mosi_on", pin_out.mosi_oe, 1);
    apb(A_DATA, 1, 32'hA5 ^ i, r);
    n = 0;
    k = 0;
    v = pin_out.sck_o;
    while (n < 16 && k < 3000) begin
      step();
      k++;
      if (pin_out.sck_o !== v) begin
        v = pin_out.sck_o;
        n++;
        if (n == 1) t0 = k;
        if (n == 2) t1 = k;
        if (n == 2 && i == 5) apb(A_DATA, 1, 32'hFF, r);
      end
    end
    if (n < 16) begin
      fail_count++;
      finish_test();
    end
    repeat (3) step();
    chk("half", t1 - t0, dv[i] / 2);
    chk("irq", irq, i == 0);
    chk("rx", prx, 8'hA5 ^ i[7:0]);
    if (i == 2) begin
      apb(A_DATA, 1, 32'h5A, r);
      repeat (12) step();
      chk("nostart", pin_out.sck_o, i[0]);
    end
    apb(A_STAT, 0, 0, r);
    chk("stat", r, i == 5 ? 32'hC0 : 32'h80);
    apb(A_DATA, 0, 0, r);
    chk("data", r, 8'h3C + i);
    apb(A_STAT, 0, 0, r);
    chk("stat", r, 0);
    sel_n <= 1'b1;
  endtask
  task automatic t_slave();
    logic [31:0] r;
    logic [7:0] got;
    slv <= 1'b1;
    apb(A_CTRL, 1, 0, r);
    apb(A_STAT, 1, 32'h3, r);
    apb(A_CTRL, 1, 32'h63, r);
    apb(A_DATA, 1, 32'h96, r);
    step();
    chk("miso_off", pin_out.miso_oe, 0);
    apb(A_STAT, 1, 32'h2, r);
    step();
    chk("miso_on", pin_out.miso_oe, 1);
    @(posedge pclk);
    for (int b = 7; b >= 0; b--) begin
      s_mosi <= SL_BYTE[b];
      repeat (4) @(posedge pclk);
      got[b] = pin_out.miso_o;
      s_sck <= 1'b1;
      repeat (4) @(posedge pclk);
      s_sck <= 1'b0;
    end
    repeat (3) step();
    chk("slave_tx", got, 8'h96);
    apb(A_STAT, 0, 0, r);
    chk("stat", r, 32'h82);
    apb(A_DATA, 0, 0, r);
    chk("data", r, {24'h0, SL_BYTE});
  endtask
  initial begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata, perr} = '0;
    {ss_n, sel_n, clock_idle_level, clock_capture_phase, ptx} = {2'h3, 10'h0};
    {slv, s_sck, s_mosi} = 3'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fault();
    for (int i = 0; i < 6; i++) t_xfer(i);
    t_slave();
    finish_test();
  end
endmodule

// >>> core/scsd_pkg.sv
// Purpose: Constants and types for the serial port control, status and data block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: Printed offsets are word indices; byte address is four times the index
//
// Summary of operation
// - Interrupt when enabled and done/fault/overrun set
// - Port enable cleared by reset and mode fault
// - Pins general I/O unless port enabled
// - Master select cleared on fault; drives clock
// - Clock polarity sets serial clock idle level
// - Phase selects first or second capture edge
// - Divider bits select CPU clock over 4..128
// - Divider bits ignored in slave mode
// - Done flag set; cleared by status then data
// - Data writes ignored while done flag pending
// - Collision flag set on write during transfer
// - Overrun set on new byte; status read clears
// - Fault set on select low; status then control
// - Output disable disconnects the data output
// - Software select ignores pin, uses internal bit
// - Internal select zero means selected
// - Master data write starts byte, loads shifter
// - Received byte copied to buffer at completion
// - Collision leaves transfer running, write discarded
// - Overrun keeps first byte, later bytes lost
// - Collision flag never requests interrupt
package scsd_pkg;
  localparam logic [7:0] SCSD_IDX_DATA = 8'h21;
  localparam logic [7:0] SCSD_IDX_CTRL = 8'h22;
  localparam logic [7:0] SCSD_IDX_STAT = 8'h23;
  localparam logic [9:0] SCSD_ADDR_DATA = {SCSD_IDX_DATA, 2'b00};
  localparam logic [9:0] SCSD_ADDR_CTRL = {SCSD_IDX_CTRL, 2'b00};
  localparam logic [9:0] SCSD_ADDR_STAT = {SCSD_IDX_STAT, 2'b00};
  localparam logic [7:0] SCSD_CTRL_RESET = 8'h00;
  localparam logic [7:0] SCSD_STAT_RESET = 8'h00;
  localparam int SCSD_CTRL_IRQ = 7;
  localparam int SCSD_CTRL_PE = 6;
  localparam int SCSD_CTRL_DIV2 = 5;
  localparam int SCSD_CTRL_MS = 4;
  localparam int SCSD_CTRL_CLOCK_IDLE_LEVEL = 3;
  localparam int SCSD_CTRL_CLOCK_CAPTURE_PHASE = 2;
  localparam int SCSD_STAT_DONE = 7;
  localparam int SCSD_STAT_WRITE_COLLISION_FLAG = 6;
  localparam int SCSD_STAT_OVR = 5;
  localparam int SCSD_STAT_MODE_FAULT_FLAG = 4;
  localparam int SCSD_STAT_SOD = 2;
  localparam int SCSD_STAT_SSM = 1;
  localparam int SCSD_STAT_SSI = 0;
  localparam logic [7:0] SCSD_STAT_WMASK = 8'h07;
  // Half serial period in CPU clocks, per divider code
  localparam logic [6:0] SCSD_HALF_DIV4 = 7'd2;
  localparam logic [6:0] SCSD_HALF_DIV8 = 7'd4;
  localparam logic [6:0] SCSD_HALF_DIV16 = 7'd8;
  localparam logic [6:0] SCSD_HALF_DIV32 = 7'd16;
  localparam logic [6:0] SCSD_HALF_DIV64 = 7'd32;
  localparam logic [6:0] SCSD_HALF_DIV128 = 7'd64;
  // Index of the final serial clock edge of a byte
  localparam logic [3:0] SCSD_LAST_EDGE = 4'hF;

  typedef enum logic [2:0] {
    SCSD_IDLE = 3'b001,
    SCSD_SHIFT = 3'b010,
    SCSD_DONE = 3'b100
  } scsd_state_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } scsd_pins_t;

  typedef struct packed {
    logic sck_i;
    logic mosi_i;
    logic miso_i;
    logic ss_n_i;
  } scsd_pin_in_t;
endpackage

// >>> core/scsd_top.sv
// Purpose: Serial port control, status and data logic behind an APB slave
// Assumes: Pin inputs synchronous to pclk; one clock domain
// Notes: Slave mode samples the external clock directly; edges seen by pclk
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
module scsd_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire scsd_pkg::scsd_pin_in_t pin_in,
  output scsd_pkg::scsd_pins_t pin_out,
  output logic alt_func_en,
  output logic ss_pin_alt_en,
  // Interrupt request
  output logic irq
);
  import scsd_pkg::*;

  // ****************************************
  // Bus decode
  // ****************************************
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] stat_q, stat_d;
  logic [7:0] rxbuf_q, rxbuf_d;
  logic [7:0] shift_q, shift_d;
  logic [6:0] div_q, div_d;
  logic [3:0] edge_q, edge_d;
  logic armed_q, armed_d;
  logic sck_q, sck_d;
  logic sck_in_q;
  logic ss_q;
  logic sample_q, sample_d;
  logic [31:0] prdata_d;
  scsd_state_t state_q, state_d;
  scsd_pins_t pins_d;

  wire access = psel && penable;
  wire hit_data = paddr[11:2] == {2'b00, SCSD_ADDR_DATA[9:2]};
  wire hit_ctrl = paddr[11:2] == {2'b00, SCSD_ADDR_CTRL[9:2]};
  wire hit_stat = paddr[11:2] == {2'b00, SCSD_ADDR_STAT[9:2]};
  wire mapped = hit_data || hit_ctrl || hit_stat;
  wire wr_data = access && pwrite && hit_data;
  wire wr_ctrl = access && pwrite && hit_ctrl;
  wire rd_stat = access && !pwrite && hit_stat;
  wire acc_data = access && hit_data;

  // ****************************************
  // Mode and select
  // ****************************************
  wire enabled = ctrl_q[SCSD_CTRL_PE];
  wire master = ctrl_q[SCSD_CTRL_MS];
  wire clock_idle_level = ctrl_q[SCSD_CTRL_CLOCK_IDLE_LEVEL];
  wire clock_capture_phase = ctrl_q[SCSD_CTRL_CLOCK_CAPTURE_PHASE];
  wire sw_sel = stat_q[SCSD_STAT_SSM];
  wire ss_level = sw_sel ? stat_q[SCSD_STAT_SSI] : pin_in.ss_n_i;
  wire fault = enabled && master && !ss_level;
  wire busy = state_q == SCSD_SHIFT;
  wire slave_sel = enabled && !master && !ss_level;
  wire [2:0] div_code = {ctrl_q[SCSD_CTRL_DIV2], ctrl_q[1:0]};
  // Armed marks the status read of a clearing sequence
  wire seq_data = armed_q && acc_data;
  wire data_wr_ok = wr_data && !(stat_q[SCSD_STAT_DONE] && !armed_q);
  wire start = master && enabled && data_wr_ok && !busy && !fault;
  wire collide = wr_data && busy;

  logic [6:0] half;
  always_comb begin
    case (div_code)
      3'b100: half = SCSD_HALF_DIV4;
      3'b000: half = SCSD_HALF_DIV8;
      3'b001: half = SCSD_HALF_DIV16;
      3'b110: half = SCSD_HALF_DIV32;
      3'b010: half = SCSD_HALF_DIV64;
      3'b011: half = SCSD_HALF_DIV128;
      default: half = SCSD_HALF_DIV128;
    endcase
  end

  wire tick = master && busy && (div_q == 7'd1);
  wire s_edge = !master && slave_sel && (pin_in.sck_i != sck_in_q);
  wire any_edge = tick || s_edge;
  // Even edge numbers capture when phase is 0, odd when phase is 1
  wire capture = any_edge && (edge_q[0] == clock_capture_phase);
  wire rx_bit = master ? pin_in.miso_i : pin_in.mosi_i;
  wire last_edge = any_edge && (edge_q == SCSD_LAST_EDGE);
  wire finish = busy && last_edge;

  // ****************************************
  // Transfer engine
  // ****************************************
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    div_d = div_q;
    edge_d = edge_q;
    sck_d = sck_q;
    sample_d = sample_q;
    rxbuf_d = rxbuf_q;
    case (state_q)
      SCSD_IDLE: begin
        sck_d = clock_idle_level;
        edge_d = 4'd0;
        div_d = half;
        if (start) begin
          shift_d = pwdata[7:0];
          state_d = SCSD_SHIFT;
        end else if (enabled && !master) begin
          if (data_wr_ok) begin
            shift_d = pwdata[7:0];
          end
          if (s_edge) begin
            state_d = SCSD_SHIFT;
            edge_d = 4'd1;
            if (!clock_capture_phase) begin
              sample_d = rx_bit;
            end
          end
        end
      end
      SCSD_SHIFT: begin
        if (master) begin
          div_d = (div_q == 7'd1) ? half : div_q - 7'd1;
          if (tick) begin
            sck_d = !sck_q;
          end
        end
        if (any_edge) begin
          edge_d = edge_q + 4'd1;
          if (capture) begin
            sample_d = rx_bit;
          end else if (edge_q != 4'd0) begin
            shift_d = {shift_q[6:0], sample_q};
          end
        end
        if (finish) begin
          shift_d = {shift_q[6:0], capture ? rx_bit : sample_q};
          state_d = SCSD_DONE;
        end
        if (!enabled || fault || (!master && ss_level)) begin
          state_d = SCSD_IDLE;
        end
      end
      SCSD_DONE: begin
        // copy only when the buffer is free
        if (!stat_q[SCSD_STAT_DONE]) begin
          rxbuf_d = shift_q;
        end
        sck_d = clock_idle_level;
        state_d = SCSD_IDLE;
      end
      default: state_d = SCSD_IDLE;
    endcase
  end

  // ****************************************
  // Registers and flags
  // ****************************************
  wire mode_fault_flag_clear = armed_q && stat_q[SCSD_STAT_MODE_FAULT_FLAG] && wr_ctrl;
  wire done_evt = state_q == SCSD_DONE;

  always_comb begin
    ctrl_d = ctrl_q;
    stat_d = stat_q;
    armed_d = armed_q;
    if (wr_ctrl && (!stat_q[SCSD_STAT_MODE_FAULT_FLAG] || mode_fault_flag_clear)) begin
      ctrl_d = pwdata[7:0];
    end else if (wr_ctrl) begin
      ctrl_d = {pwdata[7], 1'b0, pwdata[5], 1'b0, pwdata[3:0]};
    end
    if (access && pwrite && hit_stat) begin
      stat_d[2:0] = pwdata[2:0] & SCSD_STAT_WMASK[2:0];
    end
    if (rd_stat) begin
      armed_d = 1'b1;
      stat_d[SCSD_STAT_OVR] = 1'b0;
    end else if (acc_data || wr_ctrl) begin
      armed_d = 1'b0;
    end
    if (seq_data) begin
      stat_d[SCSD_STAT_DONE] = 1'b0;
      stat_d[SCSD_STAT_WRITE_COLLISION_FLAG] = 1'b0;
    end
    if (mode_fault_flag_clear) begin
      stat_d[SCSD_STAT_MODE_FAULT_FLAG] = 1'b0;
    end
    // Set wins over clear
    if (done_evt) begin
      if (stat_q[SCSD_STAT_DONE]) begin
        stat_d[SCSD_STAT_OVR] = 1'b1;
      end
      stat_d[SCSD_STAT_DONE] = 1'b1;
    end
    if (collide) begin
      stat_d[SCSD_STAT_WRITE_COLLISION_FLAG] = 1'b1;
    end
    if (fault) begin
      stat_d[SCSD_STAT_MODE_FAULT_FLAG] = 1'b1;
      ctrl_d[SCSD_CTRL_PE] = 1'b0;
      ctrl_d[SCSD_CTRL_MS] = 1'b0;
    end
    stat_d[3] = 1'b0;
  end

  // ****************************************
  // Read data and pins
  // ****************************************
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (hit_data) begin
        prdata_d = {24'h00_0000, rxbuf_q};
      end else if (hit_ctrl) begin
        prdata_d = {24'h00_0000, ctrl_q};
      end else if (hit_stat) begin
        prdata_d = {24'h00_0000, stat_q};
      end
    end else begin
      prdata_d = prdata;
    end
  end

  wire out_on = !stat_q[SCSD_STAT_SOD];
  // Hold the data output on the final edge, which may be a capture edge
  wire out_bit = finish ? shift_q[7] : shift_d[7];
  always_comb begin
    pins_d.sck_o = sck_d;
    pins_d.sck_oe = enabled && master;
    pins_d.mosi_o = out_bit;
    pins_d.mosi_oe = enabled && master && out_on;
    pins_d.miso_o = out_bit;
    pins_d.miso_oe = slave_sel && out_on;
  end

  wire irq_d = ctrl_d[SCSD_CTRL_IRQ] && (stat_d[SCSD_STAT_DONE] ||
    stat_d[SCSD_STAT_MODE_FAULT_FLAG] || stat_d[SCSD_STAT_OVR]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= SCSD_CTRL_RESET;
      stat_q <= SCSD_STAT_RESET;
      rxbuf_q <= 8'h00;
      shift_q <= 8'h00;
      div_q <= 7'h00;
      edge_q <= 4'h0;
      armed_q <= 1'b0;
      sck_q <= 1'b0;
      sck_in_q <= 1'b0;
      sample_q <= 1'b0;
      state_q <= SCSD_IDLE;
      pin_out <= '0;
      alt_func_en <= 1'b0;
      ss_pin_alt_en <= 1'b0;
      irq <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      rxbuf_q <= rxbuf_d;
      shift_q <= shift_d;
      div_q <= div_d;
      edge_q <= edge_d;
      armed_q <= armed_d;
      sck_q <= sck_d;
      sck_in_q <= pin_in.sck_i;
      sample_q <= sample_d;
      state_q <= state_d;
      pin_out <= pins_d;
      alt_func_en <= ctrl_d[SCSD_CTRL_PE];
      ss_pin_alt_en <= ctrl_d[SCSD_CTRL_PE] && !stat_d[SCSD_STAT_SSM];
      irq <= irq_d;
      prdata <= prdata_d;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end
endmodule
